//--- pkg/srr_pkg.sv
// Package for the supply monitor, wake timer and ROM pointer register bank
package srr_pkg;
  // Register addresses on the internal nibble bus
  localparam logic [7:0] ADDR_SUPPLY_CTRL   = 8'h13;
  localparam logic [7:0] ADDR_SUPPLY_THRESH = 8'h14;
  localparam logic [7:0] ADDR_RSVD_15       = 8'h15;
  localparam logic [7:0] ADDR_WAKE_CTRL     = 8'h16;
  localparam logic [7:0] ADDR_RSVD_17       = 8'h17;
  localparam logic [7:0] ADDR_PTR0          = 8'h18;
  localparam logic [7:0] ADDR_PTR1          = 8'h19;
  localparam logic [7:0] ADDR_PTR2          = 8'h1A;
  localparam logic [7:0] ADDR_PTR3          = 8'h1B;
  localparam logic [7:0] ADDR_DATA_LOW      = 8'h1C;
  localparam logic [7:0] ADDR_DATA_HIGH     = 8'h1D;
  localparam logic [7:0] ADDR_PTR4          = 8'h1E;
  localparam logic [7:0] ADDR_RSVD_1F       = 8'h1F;

  // Field positions
  localparam int SUPPLY_EN_BIT   = 0;
  localparam int SUPPLY_FLAG_BIT = 1;
  localparam int WAKE_OVF_BIT    = 3;
  localparam int WAKE_EN_BIT     = 2;
  localparam int PTR4_WIDTH      = 3;

  localparam logic [3:0] RESET_NIBBLE   = 4'h0;
  localparam logic [3:0] WAKE_CLEAR_KEY = 4'hA;
  localparam logic [3:0] NIBBLE_ZERO    = 4'h0;

  // Wake vector and post-wake settle time
  localparam logic [11:0] WAKE_VECTOR   = 12'h004;
  localparam int          SETTLE_CYCLES = 64;

  // Time base: 1 ms tick from the 50 MHz system clock
  localparam int CLK_HZ          = 50_000_000;
  localparam int TICK_MS         = 1;
  localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int PERIOD_MS_0     = 1;
  localparam int PERIOD_MS_1     = 16;
  localparam int PERIOD_MS_2     = 64;
  localparam int PERIOD_MS_3     = 128;

  // Register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [3:0] wdata;
  } srr_bus_s;

  // Wake sequencer states
  typedef enum logic [2:0] {
    WK_RUN    = 3'b001,
    WK_HALT   = 3'b010,
    WK_SETTLE = 3'b100
  } srr_wake_e;
endpackage

//--- src/srr_supply_sync.sv
// Two-stage synchroniser for the analog supply comparator level
`timescale 1ns/10ps
module srr_supply_sync
  import srr_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Level
  input  wire logic level_in,
  output logic      level_out
);
  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= level_in;
      sync_reg <= meta_reg;
    end
  end

  assign level_out = sync_reg;
endmodule

//--- src/srr_wake_timer.sv
// Wake timer: millisecond time base and period counter
`timescale 1ns/10ps
module srr_wake_timer
  import srr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Control
  input  wire logic       enable_in,
  input  wire logic [1:0] period_sel_in,
  input  wire logic       clear_in,
  // Event
  output logic            overflow_out
);
  localparam int TB_W  = $clog2(TICK_CYCLES);
  localparam logic [TB_W-1:0] TB_LAST = TB_W'(TICK_CYCLES - 1);

  logic [TB_W-1:0] base_reg;
  logic [7:0]      count_reg;
  logic            ovf_reg;
  logic [7:0]      limit;
  wire             tick = (base_reg == TB_LAST);
  wire             hit;

  // Period select in milliseconds
  assign limit = (period_sel_in == 2'b11) ? 8'(PERIOD_MS_3 - 1) :
                 (period_sel_in == 2'b10) ? 8'(PERIOD_MS_2 - 1) :
                 (period_sel_in == 2'b01) ? 8'(PERIOD_MS_1 - 1) :
                                            8'(PERIOD_MS_0 - 1);
  assign hit = enable_in && tick && (count_reg >= limit);

  // Time base runs free; counter holds while disabled, but clear_in still clears it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      base_reg  <= '0;
      count_reg <= 8'h00;
      ovf_reg   <= 1'b0;
    end else begin
      base_reg <= tick ? '0 : base_reg + 1'b1;
      ovf_reg  <= hit;
      if (clear_in)
        count_reg <= 8'h00;
      else if (hit)
        count_reg <= 8'h00;
      else if (enable_in && tick)
        count_reg <= count_reg + 8'h01;
    end
  end

  assign overflow_out = ovf_reg;
endmodule

//--- src/srr_regs.sv
// Supply monitor, wake timer and data-ROM pointer register bank
`timescale 1ns/10ps
// Functional notes
// - Supply-low bit reads one while monitor is enabled and supply is below selected threshold.
// - Monitor enable bit switches detection on or off; resets to zero.
// - Four-bit threshold code selects level from 2.1V to 3.8V.
// - Enabled timer overflow in HALT wakes core to vector 004h.
// - Overflow flag bit 3 set by hardware, cleared by software.
// - Timer enable runs timer; whole timer register resets to zero.
// - Period select gives 1, 16, 64 or 128 ms overflow.
// - Five nibble registers form a 20-bit ROM byte address.
// - Top address nibble holds only bits 2 to 0.
// - Low data port returns low nibble of addressed ROM byte.
// - High data port returns high nibble of addressed ROM byte.
// - Any write to high data port restarts the watchdog.
// - Writing A to high data port also clears the timer counter.
// - After wake the core waits 64 cycles before advancing.
module srr_regs
  import srr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Internal register bus
  input  wire logic        bus_wr_in,
  input  wire logic        bus_rd_in,
  input  wire logic [7:0]  bus_addr_in,
  input  wire logic [3:0]  bus_wdata_in,
  output logic      [3:0]  bus_rdata_out,
  // Supply comparator
  input  wire logic        supply_below_in,
  output logic             supply_monitor_enable_out,
  output logic      [3:0]  supply_threshold_out,
  // Data ROM port
  output logic      [19:0] rom_addr_out,
  input  wire logic [7:0]  rom_data_in,
  // Watchdog and core HALT control
  output logic             watchdog_clear_out,
  input  wire logic        core_halt_in,
  output logic             wake_out,
  output logic      [11:0] wake_vector_out,
  output logic             pc_hold_out
);
  srr_bus_s   bus;
  srr_wake_e  wk_reg, wk_next;

  logic       mon_en_reg;
  logic [3:0] thresh_reg;
  logic       wake_ovf_reg;
  logic       wake_en_reg;
  logic [1:0] wake_sel_reg;
  logic [3:0] ptr_reg [0:3];
  logic [PTR4_WIDTH-1:0] ptr4_reg;
  logic [3:0] rdata_reg;
  logic       wdog_reg;
  logic       wake_reg;
  logic       hold_reg;
  logic [6:0] settle_reg;
  logic       supply_low_sync;
  logic       timer_ovf;

  // Address match used by every write decode
  function automatic logic wr_hit(input srr_bus_s b, input logic [7:0] a);
    return b.wr && (b.addr == a);
  endfunction

  assign bus = '{wr: bus_wr_in, rd: bus_rd_in, addr: bus_addr_in, wdata: bus_wdata_in};

  wire wr_mon    = wr_hit(bus, ADDR_SUPPLY_CTRL);
  wire wr_thresh = wr_hit(bus, ADDR_SUPPLY_THRESH);
  wire wr_wake   = wr_hit(bus, ADDR_WAKE_CTRL);
  wire wr_dhigh  = wr_hit(bus, ADDR_DATA_HIGH);
  wire wr_ptr4   = wr_hit(bus, ADDR_PTR4);
  wire timer_clr = wr_dhigh && (bus.wdata == WAKE_CLEAR_KEY);
  wire [19:0] rom_addr = {1'b0, ptr4_reg, ptr_reg[3], ptr_reg[2], ptr_reg[1], ptr_reg[0]};

  srr_supply_sync u_sync (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .level_in  (supply_below_in),
    .level_out (supply_low_sync)
  );

  srr_wake_timer u_timer (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .enable_in     (wake_en_reg),
    .period_sel_in (wake_sel_reg),
    .clear_in      (timer_clr),
    .overflow_out  (timer_ovf)
  );

  // Supply monitor registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mon_en_reg <= 1'b0;
      thresh_reg <= RESET_NIBBLE;
    end else begin
      if (wr_mon)
        mon_en_reg <= bus.wdata[SUPPLY_EN_BIT];
      if (wr_thresh)
        thresh_reg <= bus.wdata;
    end
  end

  // Wake timer control register; hardware set wins over software clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_ovf_reg <= 1'b0;
      wake_en_reg  <= 1'b0;
      wake_sel_reg <= 2'b00;
    end else begin
      if (wr_wake) begin
        wake_en_reg  <= bus.wdata[WAKE_EN_BIT];
        wake_sel_reg <= bus.wdata[1:0];
      end
      if (timer_ovf)
        wake_ovf_reg <= 1'b1;
      else if (wr_wake && !bus.wdata[WAKE_OVF_BIT])
        wake_ovf_reg <= 1'b0;
    end
  end

  // Pointer nibbles 0..3
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ptr
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
          ptr_reg[g] <= RESET_NIBBLE;
        else if (wr_hit(bus, ADDR_PTR0 + 8'(g)))
          ptr_reg[g] <= bus.wdata;
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      ptr4_reg <= '0;
    else if (wr_ptr4)
      ptr4_reg <= bus.wdata[PTR4_WIDTH-1:0];
  end

  // Read data mux; reads have no side effects
  logic [3:0] rd_mux;
  always_comb begin
    case (bus.addr)
      ADDR_SUPPLY_CTRL:   rd_mux = {2'b00, supply_low_sync && mon_en_reg, mon_en_reg};
      ADDR_SUPPLY_THRESH: rd_mux = thresh_reg;
      ADDR_WAKE_CTRL:     rd_mux = {wake_ovf_reg, wake_en_reg, wake_sel_reg};
      ADDR_PTR0:          rd_mux = ptr_reg[0];
      ADDR_PTR1:          rd_mux = ptr_reg[1];
      ADDR_PTR2:          rd_mux = ptr_reg[2];
      ADDR_PTR3:          rd_mux = ptr_reg[3];
      ADDR_DATA_LOW:      rd_mux = rom_data_in[3:0];
      ADDR_DATA_HIGH:     rd_mux = rom_data_in[7:4];
      ADDR_PTR4:          rd_mux = {1'b0, ptr4_reg};
      default:            rd_mux = NIBBLE_ZERO;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      rdata_reg <= NIBBLE_ZERO;
    else if (bus.rd)
      rdata_reg <= rd_mux;
  end

  // Watchdog restart strobe
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      wdog_reg <= 1'b0;
    else
      wdog_reg <= wr_dhigh;
  end

  // Wake sequencer: HALT, wake on overflow, then settle
  always_comb begin
    wk_next = wk_reg;
    case (wk_reg)
      WK_RUN:    if (core_halt_in) wk_next = WK_HALT;
      WK_HALT: begin
        // Core left HALT by another source: stop waiting for the timer
        if (!core_halt_in)
          wk_next = WK_RUN;
        else if (timer_ovf && wake_en_reg)
          wk_next = WK_SETTLE;
      end
      WK_SETTLE: if (settle_reg == 7'(SETTLE_CYCLES - 1)) wk_next = WK_RUN;
      default:   wk_next = WK_RUN;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wk_reg     <= WK_RUN;
      settle_reg <= 7'h00;
      wake_reg   <= 1'b0;
      hold_reg   <= 1'b0;
    end else begin
      wk_reg     <= wk_next;
      settle_reg <= (wk_reg == WK_SETTLE) ? settle_reg + 7'h01 : 7'h00;
      wake_reg   <= (wk_reg == WK_HALT) && (wk_next == WK_SETTLE);
      hold_reg   <= (wk_next == WK_SETTLE);
    end
  end

  assign bus_rdata_out             = rdata_reg;
  assign supply_monitor_enable_out = mon_en_reg;
  assign supply_threshold_out      = thresh_reg;
  assign rom_addr_out              = rom_addr;
  assign watchdog_clear_out        = wdog_reg;
  assign wake_out                  = wake_reg;
  assign wake_vector_out           = WAKE_VECTOR;
  assign pc_hold_out               = hold_reg;
endmodule

//--- testbench/srr_regs_checker.sv
// Port assertions for the register bank
`timescale 1ns/10ps
module srr_regs_checker
  import srr_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        bus_wr_in,
  input wire logic        bus_rd_in,
  input wire logic [7:0]  bus_addr_in,
  input wire logic [3:0]  bus_wdata_in,
  input wire logic [3:0]  bus_rdata_out,
  // Watched side signals
  input wire logic        supply_monitor_enable_out,
  input wire logic [3:0]  supply_threshold_out,
  input wire logic [19:0] rom_addr_out,
  input wire logic [7:0]  rom_data_in,
  input wire logic        watchdog_clear_out,
  input wire logic        core_halt_in,
  input wire logic        wake_out,
  input wire logic [11:0] wake_vector_out,
  input wire logic        pc_hold_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic wr_high = bus_wr_in && (bus_addr_in == ADDR_DATA_HIGH);
  wdog_pulse_a: assert property (wr_high |=> watchdog_clear_out)
    else $error("watchdog clear missing");
  ptr_low_a: assert property (bus_wr_in && bus_addr_in == ADDR_PTR0
    |=> rom_addr_out[3:0] == $past(bus_wdata_in)) else $error("pointer nibble0 wrong");
  ptr_top_a: assert property (bus_wr_in && bus_addr_in == ADDR_PTR4
    |=> rom_addr_out[19:16] == {1'b0, $past(bus_wdata_in[2:0])}) else $error("top nibble wrong");
  ptr_hold_a: assert property (!bus_wr_in |=> $stable(rom_addr_out))
    else $error("pointer moved without write");
  rd_low_a: assert property (bus_rd_in && bus_addr_in == ADDR_DATA_LOW
    |=> bus_rdata_out == $past(rom_data_in[3:0])) else $error("low data read wrong");
  rd_high_a: assert property (bus_rd_in && bus_addr_in == ADDR_DATA_HIGH
    |=> bus_rdata_out == $past(rom_data_in[7:4])) else $error("high data read wrong");
  en_write_a: assert property (bus_wr_in && bus_addr_in == ADDR_SUPPLY_CTRL
    |=> supply_monitor_enable_out == $past(bus_wdata_in[0])) else $error("enable wrong");
  thr_write_a: assert property (bus_wr_in && bus_addr_in == ADDR_SUPPLY_THRESH
    |=> supply_threshold_out == $past(bus_wdata_in)) else $error("threshold wrong");
  wake_halt_a: assert property (wake_out |-> $past(core_halt_in))
    else $error("wake outside halt");
  wake_hold_a: assert property (wake_out |-> ##[0:1] pc_hold_out [*8])
    else $error("settle hold missing");
  vector_a: assert property (wake_vector_out == WAKE_VECTOR)
    else $error("wake vector wrong");
endmodule
bind srr_regs srr_regs_checker u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in), .bus_addr_in(bus_addr_in),
  .bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out),
  .supply_monitor_enable_out(supply_monitor_enable_out),
  .supply_threshold_out(supply_threshold_out), .rom_addr_out(rom_addr_out),
  .rom_data_in(rom_data_in), .watchdog_clear_out(watchdog_clear_out),
  .core_halt_in(core_halt_in), .wake_out(wake_out), .wake_vector_out(wake_vector_out),
  .pc_hold_out(pc_hold_out));

//--- testbench/srr_regs_tb.sv
// Self-checking bench for the register bank
`timescale 1ns/10ps
module srr_regs_tb
  import srr_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [3:0] d; logic [3:0] e;} srr_row_s;
  logic        clk_in, rst_n_in, below, halt, wdog, wake, hold, men;
  srr_bus_s    bus;
  logic [3:0]  rdata, thr;
  logic [11:0] vec;
  logic [7:0]  rom;
  logic [19:0] raddr;
  int          n_errors, total_checks, n;
  // Address, write nibble, expected readback
  srr_row_s rows [12] = '{16'h1311, 16'h13E0, 16'h14CC, 16'h15F0, 16'h16B3, 16'h17F0,
                          16'h1855, 16'h1966, 16'h1A77, 16'h1B88, 16'h1EF7, 16'h1FF0};
  srr_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_wr_in(bus.wr),
    .bus_rd_in(bus.rd), .bus_addr_in(bus.addr), .bus_wdata_in(bus.wdata),
    .bus_rdata_out(rdata), .supply_below_in(below), .supply_monitor_enable_out(men),
    .supply_threshold_out(thr), .rom_addr_out(raddr), .rom_data_in(rom),
    .watchdog_clear_out(wdog), .core_halt_in(halt), .wake_out(wake),
    .wake_vector_out(vec), .pc_hold_out(hold));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h", $time, m, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    @(posedge clk_in) #1;
    bus = '{1'b1, 1'b0, a, d};
    @(posedge clk_in) #1;
    bus.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [3:0] e);
    @(posedge clk_in) #1;
    bus = '{1'b0, 1'b1, a, 4'h0};
    @(posedge clk_in) #1;
    bus.rd = 1'b0;
    chk(20'(rdata), 20'(e), "read");
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    rst_n_in = 1'b0;
    bus = '0;
    below = 1'b0;
    halt = 1'b0;
    rom = 8'h3C;
    repeat (10) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    rd(ADDR_SUPPLY_CTRL, 4'h0);
    rd(ADDR_WAKE_CTRL, 4'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    chk(raddr, 20'h78765, "pointer");
    rd(ADDR_DATA_LOW, 4'hC);
    rd(ADDR_DATA_HIGH, 4'h3);
    chk(raddr, 20'h78765, "pointer after read");
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_SUPPLY_THRESH, 4'(i));
      chk(20'(thr), 20'(i), "threshold");
    end
    $display("test table done");
    wr(ADDR_SUPPLY_CTRL, 4'h1);
    chk(20'(men), 20'h1, "monitor enable");
    below = 1'b1;
    repeat (3) @(posedge clk_in);
    rd(ADDR_SUPPLY_CTRL, 4'h3);
    wr(ADDR_SUPPLY_CTRL, 4'h0);
    chk(20'(men), 20'h0, "monitor disable");
    rd(ADDR_SUPPLY_CTRL, 4'h0);
    wr(ADDR_DATA_HIGH, WAKE_CLEAR_KEY);
    chk(20'(wdog), 20'h1, "watchdog clear");
    @(posedge clk_in) #1;
    chk(20'(wdog), 20'h0, "watchdog pulse length");
    $display("test supply done");
    halt = 1'b1;
    wr(ADDR_WAKE_CTRL, 4'h4);
    n = 0;
    while (wake !== 1'b1 && n < 60000) begin
      @(posedge clk_in) #1;
      n++;
    end
    chk(20'(n < 60000), 20'h1, "no wake");
    if (n < 60000) begin
      chk(20'(vec), 20'h00004, "wake vector");
      n = 0;
      repeat (100) begin
        if (hold === 1'b1)
          n++;
        @(posedge clk_in) #1;
      end
      chk(20'(n), 20'h40, "settle length");
      rd(ADDR_WAKE_CTRL, 4'hC);
      wr(ADDR_WAKE_CTRL, 4'h4);
      rd(ADDR_WAKE_CTRL, 4'h4);
    end
    $display("test wake done");
    rst_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1 rst_n_in = 1'b1;
    rd(ADDR_WAKE_CTRL, 4'h0);
    chk(raddr, 20'h0, "pointer after reset");
    $display("test second reset done");
    summarize();
  end
endmodule
